//--- core/lit_defs.svh
`ifndef LIT_DEFS_SVH
`define LIT_DEFS_SVH

// Byte addresses of the register words
`define LIT_OFS_INIT 12'h380
`define LIT_OFS_CUR  12'h390
`define LIT_OFS_DIV  12'h3E0
`define LIT_OFS_FEAT 12'h400
`define LIT_OFS_CTRL 12'h410
`define LIT_OFS_EOI  12'h420
`define LIT_OFS_STAT 12'h440
`define LIT_OFS_MASK 12'h450

// Reset value shared by every writable register
`define LIT_RST_WORD 32'h0000_0000

// Feature word fields
`define LIT_FEAT_CNT_LSB 16
`define LIT_FEAT_CNT     8'h04
`define LIT_FEAT_WIDE    2
`define LIT_FEAT_TEOI    1
`define LIT_FEAT_VEN     0

// Divide select and control fields
`define LIT_DIV_HI  3
`define LIT_CTRL_W  3
`define LIT_EVT_W   3
`define LIT_VEC_W   8

// Destination broadcast patterns
`define LIT_BCAST_NARROW 4'hF
`define LIT_BCAST_WIDE   8'hFF

// Bus answers
`define LIT_RESP_OKAY   2'h0
`define LIT_RESP_SLVERR 2'h2

`endif

//--- core/lit_pkg.sv
package lit_pkg;

	// Extended control word, bit 2 down to bit 0
	typedef struct packed {
		logic wide_identifier_enable;
		logic targeted_eoi_enable;
		logic vector_enable_write_enable;
	} lit_ctrl_t;

	// Sticky events, bit 2 down to bit 0
	typedef struct packed {
		logic enable_write_refused;
		logic eoi_done;
		logic timer_expired;
	} lit_evt_t;

endpackage

//--- core/lit_timer_ctrl.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "lit_defs.svh"
module lit_timer_ctrl import lit_pkg::*; (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        timer_periodic,
	input  wire logic        identifier_extension_bit,
	input  wire logic        broadcast_extension_bit,
	input  wire logic [7:0]  local_identifier,
	input  wire logic        dest_valid,
	input  wire logic [7:0]  interrupt_destination,
	input  wire logic        vector_enable_wr_req,
	output logic             vector_enable_wr_grant,
	output logic             dest_match,
	output logic             dest_broadcast,
	output logic             wide_identifier_active,
	output logic             eoi_cycle,
	output logic [7:0]       eoi_vector,
	output logic             targeted_eoi_message,
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Last prescaler count of a divided period: divisor minus one
	function automatic logic [6:0] div_last(input logic [3:0] sel);
		logic [6:0] r;
		r = 7'h00;
		case ({sel[`LIT_DIV_HI], sel[1:0]})
			3'h0:    r = 7'h01;
			3'h1:    r = 7'h03;
			3'h2:    r = 7'h07;
			3'h3:    r = 7'h0F;
			3'h4:    r = 7'h1F;
			3'h5:    r = 7'h3F;
			3'h6:    r = 7'h7F;
			default: r = 7'h00;
		endcase
		return r;
	endfunction

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		return a == `LIT_OFS_INIT || a == `LIT_OFS_CUR || a == `LIT_OFS_DIV
			|| a == `LIT_OFS_FEAT || a == `LIT_OFS_CTRL || a == `LIT_OFS_EOI
			|| a == `LIT_OFS_STAT || a == `LIT_OFS_MASK;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State

	logic [31:0]  init_reg;
	logic [31:0]  cur_reg;
	logic [3:0]   div_reg;
	logic [6:0]   presc_reg;
	lit_ctrl_t    ctrl_reg;
	logic [7:0]   eoi_reg;
	lit_evt_t     status_reg;
	lit_evt_t     mask_reg;
	logic         aw_have_reg;
	logic         w_have_reg;
	logic [11:0]  awaddr_reg;
	logic [31:0]  wdata_reg;
	logic [3:0]   wstrb_reg;
	logic         wr_go;
	logic         tick;
	logic         expire;
	logic         wide;
	logic [31:0]  wr_word;
	logic [31:0]  feat_word;
	lit_evt_t     evt_set;
	lit_evt_t     evt_clr;

	// A write commits once both halves are held and no answer is pending
	assign wr_go   = aw_have_reg & w_have_reg & ~bvalid;
	assign tick    = (cur_reg != 32'h0000_0000) && (presc_reg == div_last(div_reg));
	assign expire  = tick && (cur_reg == 32'h0000_0001);
	assign wide    = ctrl_reg.wide_identifier_enable
		| (identifier_extension_bit & broadcast_extension_bit);
	assign wr_word = merge(32'h0000_0000, wdata_reg, wstrb_reg);

	// Capability word is wired, nothing to store
	assign feat_word = {8'h00, `LIT_FEAT_CNT, 13'h0000,
		1'b1,
		1'b1,
		1'b1};

	////////////////////////////////////////////////////////////////////////////
	// Bus slave

	// Write address and data are taken independently, released after the answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			awready     <= 1'b1;
			awaddr_reg  <= 12'h000;
		end else if (awvalid && awready) begin
			aw_have_reg <= 1'b1;
			awready     <= 1'b0;
			awaddr_reg  <= {awaddr[11:2], 2'h0};
		end else if (bvalid && bready) begin
			aw_have_reg <= 1'b0;
			awready     <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_reg <= 1'b0;
			wready     <= 1'b1;
			wdata_reg  <= `LIT_RST_WORD;
			wstrb_reg  <= 4'h0;
		end else if (wvalid && wready) begin
			w_have_reg <= 1'b1;
			wready     <= 1'b0;
			wdata_reg  <= wdata;
			wstrb_reg  <= wstrb;
		end else if (bvalid && bready) begin
			w_have_reg <= 1'b0;
			wready     <= 1'b1;
		end
	end

	// Unmapped words answer SLVERR; a write to a read-only word is accepted silently
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `LIT_RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp  <= mapped(awaddr_reg) ? `LIT_RESP_OKAY : `LIT_RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// Reads answer one cycle after the address is taken; reserved bits read zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= `LIT_RST_WORD;
			rresp   <= `LIT_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= mapped({araddr[11:2], 2'h0}) ? `LIT_RESP_OKAY : `LIT_RESP_SLVERR;
			case ({araddr[11:2], 2'h0})
				`LIT_OFS_INIT: rdata <= init_reg;
				`LIT_OFS_CUR:  rdata <= cur_reg;
				`LIT_OFS_DIV:  rdata <= {28'h0000000, div_reg};
				`LIT_OFS_FEAT: rdata <= feat_word;
				`LIT_OFS_CTRL: rdata <= {29'h00000000, ctrl_reg};
				`LIT_OFS_EOI:  rdata <= {24'h000000, eoi_reg};
				`LIT_OFS_STAT: rdata <= {29'h00000000, status_reg};
				`LIT_OFS_MASK: rdata <= {29'h00000000, mask_reg};
				default:       rdata <= `LIT_RST_WORD;
			endcase
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Software registers

	// Plain read-write words; the divide word keeps its reserved bit at zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_reg <= `LIT_RST_WORD;
			div_reg  <= 4'h0;
			ctrl_reg <= lit_ctrl_t'(3'h0);
			mask_reg <= lit_evt_t'(3'h0);
		end else if (wr_go) begin
			case (awaddr_reg)
				`LIT_OFS_INIT: init_reg <= merge(init_reg, wdata_reg, wstrb_reg);
				`LIT_OFS_DIV: if (wstrb_reg[0]) begin
					div_reg <= {wdata_reg[`LIT_DIV_HI], 1'b0, wdata_reg[1:0]};
				end
				`LIT_OFS_CTRL: if (wstrb_reg[0]) begin
					ctrl_reg <= lit_ctrl_t'(wdata_reg[`LIT_CTRL_W-1:0]);
				end
				`LIT_OFS_MASK: if (wstrb_reg[0]) begin
					mask_reg <= lit_evt_t'(wdata_reg[`LIT_EVT_W-1:0]);
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timer

	// A load restarts both the count and the prescaler so the first period is whole
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur_reg   <= `LIT_RST_WORD;
			presc_reg <= 7'h00;
		end else if (wr_go && awaddr_reg == `LIT_OFS_INIT) begin
			cur_reg   <= merge(init_reg, wdata_reg, wstrb_reg);
			presc_reg <= 7'h00;
		end else if (cur_reg == 32'h0000_0000) begin
			presc_reg <= 7'h00;
		end else if (tick) begin
			presc_reg <= 7'h00;
			if (expire && timer_periodic) begin
				cur_reg <= init_reg;
			end else begin
				cur_reg <= cur_reg - 32'h0000_0001;
			end
		end else begin
			presc_reg <= presc_reg + 7'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// End of interrupt

	// Only the low byte carries the vector; the upper lanes are reserved
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eoi_reg              <= 8'h00;
			eoi_cycle            <= 1'b0;
			eoi_vector           <= 8'h00;
			targeted_eoi_message <= 1'b0;
		end else if (wr_go && awaddr_reg == `LIT_OFS_EOI && wstrb_reg[0]) begin
			eoi_reg              <= wdata_reg[`LIT_VEC_W-1:0];
			eoi_cycle            <= 1'b1;
			eoi_vector           <= wdata_reg[`LIT_VEC_W-1:0];
			targeted_eoi_message <= ctrl_reg.targeted_eoi_enable;
		end else begin
			eoi_cycle            <= 1'b0;
			targeted_eoi_message <= 1'b0;
		end
	end

	// Enable-register writes live elsewhere; this block only grants or refuses them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vector_enable_wr_grant <= 1'b0;
		end else begin
			vector_enable_wr_grant <= vector_enable_wr_req
				& ctrl_reg.vector_enable_write_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Destination matching

	// Registered so the compare path does not reach the outputs combinationally
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dest_match             <= 1'b0;
			dest_broadcast         <= 1'b0;
			wide_identifier_active <= 1'b0;
		end else begin
			wide_identifier_active <= wide;
			if (wide) begin
				dest_match     <= dest_valid && interrupt_destination == local_identifier;
				dest_broadcast <= dest_valid
					&& interrupt_destination == `LIT_BCAST_WIDE;
			end else begin
				dest_match     <= dest_valid
					&& interrupt_destination[3:0] == local_identifier[3:0];
				dest_broadcast <= dest_valid
					&& interrupt_destination[3:0] == `LIT_BCAST_NARROW;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status

	assign evt_set = '{enable_write_refused: vector_enable_wr_req
			& ~ctrl_reg.vector_enable_write_enable,
		eoi_done: wr_go && awaddr_reg == `LIT_OFS_EOI && wstrb_reg[0],
		timer_expired: expire};
	assign evt_clr = (wr_go && awaddr_reg == `LIT_OFS_STAT)
		? lit_evt_t'(wr_word[`LIT_EVT_W-1:0]) : lit_evt_t'(3'h0);

	// A new event beats a clear in the same cycle, so none is lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= lit_evt_t'(3'h0);
			irq        <= 1'b0;
		end else begin
			status_reg <= (status_reg & ~evt_clr) | evt_set;
			irq        <= |(((status_reg & ~evt_clr) | evt_set) & mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_load_copy: assert property (wr_go && awaddr_reg == `LIT_OFS_INIT
		&& wstrb_reg == 4'hF |=> cur_reg == $past(wdata_reg) && init_reg == $past(wdata_reg))
		else $error("load did not copy initial count");

	a_current_ro: assert property (wr_go && awaddr_reg == `LIT_OFS_CUR && !tick
		|=> cur_reg == $past(cur_reg))
		else $error("write to current count changed the counter");

	a_div_one: assert property (div_reg == 4'hB && cur_reg > 32'h1 && !wr_go
		|=> cur_reg == $past(cur_reg) - 32'h1)
		else $error("divide by one did not count every cycle");

	a_div_two: assert property (div_reg == 4'h0 && cur_reg > 32'h2 && !wr_go
		&& tick ##1 !wr_go ##1 !wr_go |-> cur_reg == $past(cur_reg, 2) - 32'h1)
		else $error("divide by two tick spacing wrong");

	a_feat_word: assert property (arvalid && arready
		&& araddr == `LIT_OFS_FEAT |=> rdata == 32'h0004_0007 && rvalid)
		else $error("feature word wrong");

	a_stop_zero: assert property (cur_reg == 32'h0 && !wr_go |=> cur_reg == 32'h0)
		else $error("timer moved from zero without a load");

	a_wide_match: assert property (wide && dest_valid
		&& interrupt_destination == local_identifier |=> dest_match)
		else $error("wide identifier match missed");

	a_narrow_bcast: assert property (!wide && dest_valid
		&& interrupt_destination[3:0] == 4'hF |=> dest_broadcast)
		else $error("narrow broadcast missed");

	a_eoi_gate: assert property (wr_go && awaddr_reg == `LIT_OFS_EOI
		&& wstrb_reg[0] |=> eoi_cycle && eoi_vector == $past(wdata_reg[7:0])
		&& targeted_eoi_message == $past(ctrl_reg.targeted_eoi_enable))
		else $error("end of interrupt cycle wrong");

	a_enable_gate: assert property (vector_enable_wr_req
		&& !ctrl_reg.vector_enable_write_enable |=> !vector_enable_wr_grant)
		else $error("enable write granted while disabled");

endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
`include "lit_defs.svh"
module tb_top;
	import lit_pkg::*;

	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        timer_periodic, identifier_extension_bit, broadcast_extension_bit;
	logic [7:0]  local_identifier, interrupt_destination, eoi_vector, vec_seen;
	logic        dest_valid, vector_enable_wr_req, vector_enable_wr_grant, dest_match;
	logic        dest_broadcast, wide_identifier_active, eoi_cycle, targeted_eoi_message;
	int          error_cnt, tests_run, eoi_seen, tmsg_seen;

	lit_timer_ctrl i_lit_timer_ctrl (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .timer_periodic, .identifier_extension_bit,
		.broadcast_extension_bit, .local_identifier, .dest_valid, .interrupt_destination,
		.vector_enable_wr_req, .vector_enable_wr_grant, .dest_match, .dest_broadcast,
		.wide_identifier_active, .eoi_cycle, .eoi_vector, .targeted_eoi_message, .irq);

	////////////////////////////////////////////////////////////////////////////////
	// Clock at 125 MHz
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// Pulses last one cycle, so they are counted here rather than polled
	always @(posedge aclk) begin
		if (eoi_cycle === 1'b1) begin
			eoi_seen++;
			vec_seen <= eoi_vector;
		end
		if (targeted_eoi_message === 1'b1)
			tmsg_seen++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask

	// Address and data offered together; each released at its own handshake
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		bit aw, w;
		aw = 0;
		w = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && awready === 1'b1) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge aclk);
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_write(a, d, 4'hF, r);
		chk("bresp", {30'h0, `LIT_RESP_OKAY}, {30'h0, r});
	endtask

	task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(a, d, r);
		chk(nm, exp, d);
		chk("rresp", {30'h0, `LIT_RESP_OKAY}, {30'h0, r});
	endtask

	task automatic wait_irq(output int n);
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(posedge aclk);
			n++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_reset;
		logic [31:0] d;
		logic [1:0]  r;
		rd_chk("initial", `LIT_OFS_INIT, 32'h0);
		rd_chk("current", `LIT_OFS_CUR, 32'h0);
		rd_chk("divide", `LIT_OFS_DIV, 32'h0);
		rd_chk("feature", `LIT_OFS_FEAT, 32'h0004_0007);
		wr(`LIT_OFS_FEAT, 32'h0);
		rd_chk("feature kept", `LIT_OFS_FEAT, 32'h0004_0007);
		rd_chk("control", `LIT_OFS_CTRL, 32'h0);
		rd_chk("eoi", `LIT_OFS_EOI, 32'h0);
		axi_read(12'h500, d, r);
		chk("unmapped resp", {30'h0, `LIT_RESP_SLVERR}, {30'h0, r});
		chk("unmapped data", 32'h0, d);
		axi_write(12'h7FC, 32'hFFFF_FFFF, 4'hF, r);
		chk("unmapped wresp", {30'h0, `LIT_RESP_SLVERR}, {30'h0, r});
		$display("test reset done");
	endtask

	// Every divide code, timed from load to expiry; slack covers the status stage
	task automatic test_timer;
		int n, i;
		int dv[8] = '{2, 4, 8, 16, 32, 64, 128, 1};
		logic [31:0] cd[8] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h8, 32'h9, 32'hA, 32'hB};
		logic [31:0] d;
		logic [1:0]  r;
		wr(`LIT_OFS_MASK, 32'h1);
		for (i = 0; i < 8; i++) begin
			wr(`LIT_OFS_DIV, cd[i]);
			wr(`LIT_OFS_STAT, 32'h7);
			wr(`LIT_OFS_INIT, 32'h3);
			wait_irq(n);
			chk("expiry time", 32'h1, {31'h0, n >= 3 * dv[i] - 2 && n <= 3 * dv[i] + 3});
			rd_chk("stopped", `LIT_OFS_CUR, 32'h0);
		end
		wr(`LIT_OFS_DIV, 32'hFFFF_FFFF);
		rd_chk("div reserved", `LIT_OFS_DIV, 32'hB);
		wr(`LIT_OFS_CUR, 32'h55);
		rd_chk("current ro", `LIT_OFS_CUR, 32'h0);
		axi_write(`LIT_OFS_INIT, 32'h1234_5678, 4'h5, r);
		rd_chk("initial lanes", `LIT_OFS_INIT, 32'h0034_0078);
		axi_read(`LIT_OFS_CUR, d, r);
		chk("counting", 32'h1, {31'h0, d != 0 && d < 32'h0034_0078});
		wr(`LIT_OFS_INIT, 32'h0);
		wr(`LIT_OFS_STAT, 32'h7);
		repeat (20) @(posedge aclk);
		rd_chk("zero load", `LIT_OFS_CUR, 32'h0);
		chk("no expiry", 32'h0, {31'h0, irq});
		timer_periodic <= 1'b1;
		wr(`LIT_OFS_INIT, 32'h3);
		wait_irq(n);
		wr(`LIT_OFS_STAT, 32'h1);
		wait_irq(n);
		chk("reload", 32'h1, {31'h0, n <= 8});
		timer_periodic <= 1'b0;
		wr(`LIT_OFS_INIT, 32'h0);
		wr(`LIT_OFS_STAT, 32'h7);
		$display("test timer done");
	endtask

	task automatic test_eoi;
		wr(`LIT_OFS_CTRL, 32'hFF);
		rd_chk("control bits", `LIT_OFS_CTRL, 32'h7);
		wr(`LIT_OFS_CTRL, 32'h2);
		// Pulse counters start at zero and only the pulse monitor writes them
		wr(`LIT_OFS_EOI, 32'h1A5);
		repeat (3) @(posedge aclk);
		chk("eoi pulses", 32'h1, eoi_seen);
		chk("eoi vector", 32'hA5, {24'h0, vec_seen});
		chk("message", 32'h1, tmsg_seen);
		rd_chk("eoi readback", `LIT_OFS_EOI, 32'hA5);
		wr(`LIT_OFS_CTRL, 32'h0);
		wr(`LIT_OFS_EOI, 32'h5C);
		repeat (3) @(posedge aclk);
		chk("eoi pulses off", 32'h2, eoi_seen);
		chk("no message", 32'h1, tmsg_seen);
		wr(`LIT_OFS_MASK, 32'h0);
		repeat (2) @(posedge aclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(`LIT_OFS_MASK, 32'h2);
		repeat (2) @(posedge aclk);
		chk("irq eoi", 32'h1, {31'h0, irq});
		wr(`LIT_OFS_STAT, 32'h2);
		repeat (2) @(posedge aclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("test eoi done");
	endtask

	// Grant only while the write-enable control bit is set; a refusal is logged
	task automatic test_gate;
		int i;
		for (i = 1; i >= 0; i--) begin
			wr(`LIT_OFS_CTRL, i);
			@(posedge aclk);
			vector_enable_wr_req <= 1'b1;
			@(posedge aclk);
			vector_enable_wr_req <= 1'b0;
			@(posedge aclk);
			chk("grant", i, {31'h0, vector_enable_wr_grant});
		end
		rd_chk("refused", `LIT_OFS_STAT, 32'h4);
		wr(`LIT_OFS_STAT, 32'h7);
		$display("test gate done");
	endtask

	// Narrow, control-bit wide, extension-bit wide, one extension bit only
	task automatic test_dest;
		int m, j;
		bit wide;
		logic [7:0] ds[4] = '{8'h25, 8'h35, 8'h3F, 8'hFF};
		local_identifier <= 8'h35;
		dest_valid <= 1'b1;
		for (m = 0; m < 4; m++) begin
			wide = (m == 1 || m == 2);
			wr(`LIT_OFS_CTRL, (m == 1) ? 32'h4 : 32'h0);
			identifier_extension_bit <= (m >= 2);
			broadcast_extension_bit <= (m == 2);
			for (j = 0; j < 4; j++) begin
				interrupt_destination <= ds[j];
				repeat (3) @(posedge aclk);
				chk("wide", {31'h0, wide}, {31'h0, wide_identifier_active});
				chk("match", {31'h0, wide ? ds[j] == 8'h35 : ds[j][3:0] == 4'h5},
					{31'h0, dest_match});
				chk("bcast", {31'h0, wide ? ds[j] == 8'hFF : ds[j][3:0] == 4'hF},
					{31'h0, dest_broadcast});
			end
		end
		dest_valid <= 1'b0;
		interrupt_destination <= 8'h35;
		repeat (3) @(posedge aclk);
		chk("no dest", 32'h0, {31'h0, dest_match});
		$display("test dest done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// The whole sequence needs about 1200 cycles
	initial begin
		repeat (30000) @(posedge aclk);
		error_cnt++;
		give_verdict();
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, timer_periodic} = '0;
		{identifier_extension_bit, broadcast_extension_bit, dest_valid} = '0;
		{awaddr, araddr, wdata, wstrb, local_identifier, interrupt_destination} = '0;
		vector_enable_wr_req = 1'b0;
		error_cnt = 0;
		tests_run = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		test_reset();
		test_timer();
		test_eoi();
		test_gate();
		test_dest();
		give_verdict();
	end
endmodule
